/* File: bench/bridge_link_monitor.sv */
`default_nettype none
module bridge_link_monitor (
  // Clock and reset
  input wire logic                     mclk_in,
  input wire logic                     rst_in,
  // Link signals
  input wire logic                     bus_cycle,
  input wire logic                     ms_mode,
  input wire logic [7:0]               range_cfg,
  input wire logic [7:0]               period_cfg,
  input wire logic [7:0]               status,
  input wire logic [31:0]              raw,
  input wire bridge_pkg::slot_vec_type slots,
  input wire logic                     pub
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned gap_r;
  int unsigned len_r;
  int unsigned per;
  int unsigned n_c;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // Measured bus cycle length, valid in the publish cycle
  always_ff @(posedge mclk_in)
  begin
    if (rst_in || bus_cycle) gap_r <= 0;
    else gap_r <= gap_r + 1;
  end
  always_ff @(posedge mclk_in)
  begin
    if (rst_in) len_r <= 0;
    else if (bus_cycle) len_r <= gap_r + 1;
  end
  // Reserved period codes fall back to the short period
  assign per = (period_cfg == bridge_pkg::PERIOD_SEL_B) ? bridge_pkg::PERIOD_B_CYC
                                                        : bridge_pkg::PERIOD_A_CYC;
  assign n_c = (len_r / per > 10) ? 10 : len_r / per;
  sequence s_boundary;
    bus_cycle;
  endsequence
  sequence s_ms_pub;
    ms_mode && pub;
  endsequence
  a_pub_follows: assert property (s_boundary |=> pub) else $error("publish missing");
  a_pub_cause: assert property (pub |-> $past(bus_cycle)) else $error("stray publish");
  a_slots_hold: assert property (!$past(bus_cycle) |-> $stable(slots))
    else $error("slots changed between boundaries");
  a_status_reserved: assert property (status[7:3] == 5'h00) else $error("reserved bits");
  a_raw_sign: assert property (raw[31:23] == {9{raw[23]}}) else $error("raw not 24 bit");
  a_invalid_code: assert property (!ms_mode && !$past(ms_mode) && status[0]
    |-> raw == bridge_pkg::RAW_INVALID) else $error("invalid flag without code");
  a_unlock_empty: assert property (s_ms_pub ##0 status[2]
    |-> slots == {10{bridge_pkg::SLOT_INVALID}}) else $error("unlocked slots not invalid");
  a_misalign_nosync: assert property (s_ms_pub ##0 (len_r % per != 0) |-> status[2])
    else $error("misaligned cycle shown locked");
  a_range_clean: assert property (range_cfg[7:3] == 5'h00) else $error("range high bits");
  for (genvar k = 0; k < 10; k++)
  begin : g_tail
    a_tail_invalid: assert property (s_ms_pub ##0 (!status[2] && k >= n_c)
      |-> slots[k] == bridge_pkg::SLOT_INVALID) else $error("unfilled slot not invalid");
  end
endmodule : bridge_link_monitor
`default_nettype wire

/* File: bench/bridge_sensor_result_and_multisample_tb.sv */
`default_nettype none
module bridge_sensor_result_and_multisample_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [23:0] adc_data = 24'h000000;
  logic        adc_valid = 1'b0, adc_cfg = 1'b1, open_line = 1'b0;
  logic        br_fault = 1'b0, io_fault = 1'b0, upd = 1'b0, last_ns = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rd_v;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, conv_start;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] rdata;
  logic [2:0]  range_code;
  logic [15:0] hist[$];
  logic [15:0] exp_s0 = 16'h0;
  int          error_cnt = 0, tests_run = 0, cyc_cnt = 0, pubs = 0, exp_n = 0, exp_all = 0;
  // Short settling keeps the run small
  meas_link_if u_meas_link_if ();
  bridge_dev_end #(.SETTLE_CYCLES(1)) u_bridge_dev_end (.mclk_in(mclk_in), .rst_in(rst_in),
    .link(u_meas_link_if.dev), .adc_data_in(adc_data), .adc_valid_in(adc_valid),
    .adc_configured_in(adc_cfg), .open_line_in(open_line), .bridge_fault_in(br_fault),
    .io_fault_in(io_fault), .conv_start_out(conv_start), .range_code_out(range_code),
    .sync_locked_out());
  bridge_host_end u_bridge_host_end (.mclk_in(mclk_in), .rst_in(rst_in),
    .link(u_meas_link_if.host), .axi_awaddr_in(awaddr), .axi_awvalid_in(awvalid),
    .axi_awready_out(awready), .axi_wdata_in(wdata), .axi_wstrb_in(4'hf),
    .axi_wvalid_in(wvalid), .axi_wready_out(wready), .axi_bresp_out(bresp),
    .axi_bvalid_out(bvalid), .axi_bready_in(bready), .axi_araddr_in(araddr),
    .axi_arvalid_in(arvalid), .axi_arready_out(arready), .axi_rdata_out(rdata),
    .axi_rresp_out(rresp), .axi_rvalid_out(rvalid), .axi_rready_in(rready), .irq_out(irq));
  bridge_link_monitor u_bridge_link_monitor (.mclk_in(mclk_in), .rst_in(rst_in),
    .bus_cycle(u_meas_link_if.bus_cycle), .ms_mode(u_meas_link_if.ms_mode),
    .range_cfg(u_meas_link_if.range_cfg), .period_cfg(u_meas_link_if.period_cfg),
    .status(u_meas_link_if.status), .raw(u_meas_link_if.raw),
    .slots(u_meas_link_if.slots), .pub(u_meas_link_if.pub));
  // Clock and hang guard
  initial forever #25 mclk_in = ~mclk_in;
  always @(posedge mclk_in)
  begin
    if (upd) adc_data <= 24'($urandom);
    upd = 1'b0;
    cyc_cnt++;
    if (cyc_cnt == 95000)
    begin
      error_cnt++;
      wrap_up();
    end
  end
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task check_slot(input int k, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] slot %0d expected %h seen %h", k, exp, got);
    end
  endtask : check_slot
  task wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  // Both channels offered together, each released once taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t;
    aw_t = 1'b0;
    w_t = 1'b0;
    @(posedge mclk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_t && w_t))
    begin
      @(negedge mclk_in);
      aw_t = aw_t | (awvalid & awready);
      w_t = w_t | (wvalid & wready);
      @(posedge mclk_in);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
    do @(negedge mclk_in); while (bvalid !== 1'b1);
    check("write resp", {30'h0, er}, {30'h0, bresp});
    @(posedge mclk_in);
    bready <= 1'b0;
  endtask : wr
  task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    @(posedge mclk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge mclk_in); while (arready !== 1'b1);
    @(posedge mclk_in);
    arvalid <= 1'b0;
    do @(negedge mclk_in); while (rvalid !== 1'b1);
    check("read data", e, rdata & m);
    check("read resp", {30'h0, er}, {30'h0, rresp});
    @(posedge mclk_in);
    rready <= 1'b0;
  endtask : rd_chk
  // Reference model: history of conversions, compared at each locked multisample publish
  always @(negedge mclk_in)
  begin
    logic any_open;
    any_open = 1'b0;
    if (!rst_in && conv_start)
    begin
      hist.push_back(open_line ? bridge_pkg::SLOT_POS_FS : adc_data[23:8]);
      upd = 1'b1;
    end
    if (!rst_in && u_meas_link_if.pub && u_meas_link_if.ms_mode)
    begin
      last_ns = u_meas_link_if.status[2];
      if (!last_ns)
      begin
        for (int k = 0; k < bridge_pkg::SLOT_COUNT; k++)
          check_slot(k, (k < exp_n) ? hist[hist.size() - exp_n + k] : bridge_pkg::SLOT_INVALID,
            u_meas_link_if.slots[k]);
        for (int k = 0; k < exp_all && k < hist.size(); k++)
          any_open = any_open | (hist[hist.size() - 1 - k] == bridge_pkg::SLOT_POS_FS);
        check("open flag", {31'h0, any_open}, {31'h0, u_meas_link_if.status[1]});
        exp_s0 = hist[hist.size() - exp_n];
      end
      pubs++;
    end
  end
  // One multisampling configuration; open line for one cycle when asked
  task ms_run(input int cyc_us, input int per, input int ncyc, input int open_at);
    int pc;
    pc = (per == 1) ? bridge_pkg::PERIOD_B_CYC : bridge_pkg::PERIOD_A_CYC;
    exp_all = cyc_us * bridge_pkg::CLK_PER_US / pc;
    exp_n = (exp_all > bridge_pkg::SLOT_COUNT) ? bridge_pkg::SLOT_COUNT : exp_all;
    wr(bridge_pkg::REG_PERIOD, per, 2'b00);
    wr(bridge_pkg::REG_CYCLE, cyc_us, 2'b00);
    hist.delete();
    pubs = 0;
    wr(bridge_pkg::REG_CTRL, 32'h3, 2'b00);
    if (open_at > 0)
    begin
      wait (pubs == open_at);
      @(posedge mclk_in) open_line <= 1'b1;
      wait (pubs == open_at + 1);
      @(posedge mclk_in) open_line <= 1'b0;
    end
    wait (pubs == ncyc);
    wr(bridge_pkg::REG_CTRL, 32'h0, 2'b00);
    check("lock state", (cyc_us * 20 % pc == 0) ? 0 : 1, {31'h0, last_ns});
  endtask : ms_run
  // Main sequence
  initial
  begin
    logic [7:0]  ra[6];
    logic [31:0] rm[6];
    logic [31:0] rv[6];
    logic [23:0] v;
    ra = '{bridge_pkg::REG_CTRL, bridge_pkg::REG_CYCLE, bridge_pkg::REG_RANGE,
           bridge_pkg::REG_PERIOD, bridge_pkg::REG_IRQ_MASK, bridge_pkg::REG_SLOT_EN};
    rm = '{32'h7, 32'hffff, 32'h7, 32'hff, 32'hf, 32'hf};
    rv = '{32'h0, {16'h0, bridge_pkg::CYCLE_US_RST}, 32'h0, 32'h0, 32'h0, 32'ha};
    rd_v = $urandom(32'he5eb);
    repeat (4) @(posedge mclk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 6; i++) rd_chk(ra[i], rm[i], rv[i], 2'b00);
    rd_chk(8'h24, 32'hffffffff, 32'h0, 2'b10);
    wr(8'h24, 32'h1, 2'b10);
    wr(bridge_pkg::REG_PERIOD, 32'h2, 2'b00);
    rd_chk(bridge_pkg::REG_PERIOD, 32'hff, 32'h0, 2'b00);
    wr(bridge_pkg::REG_SLOT_EN, 32'hb, 2'b00);
    rd_chk(bridge_pkg::REG_SLOT_EN, 32'hf, 32'ha, 2'b00);
    for (int r = 0; r < 8; r++)
    begin
      wr(bridge_pkg::REG_RANGE, r, 2'b00);
      @(negedge mclk_in);
      check("range code", r, {29'h0, range_code});
      check("range cfg", r, {24'h0, u_meas_link_if.range_cfg});
    end
    // Standard raw values, boundary input first
    for (int i = 0; i < 6; i++)
    begin
      v = (i == 0) ? bridge_pkg::ADC_MIN : ((i == 1) ? 24'h7ffffe : 24'($urandom));
      @(posedge mclk_in);
      adc_data <= v;
      adc_valid <= 1'b1;
      @(posedge mclk_in) adc_valid <= 1'b0;
      repeat (3) @(negedge mclk_in);
      check("raw", (v == bridge_pkg::ADC_MIN) ? bridge_pkg::RAW_NEG_FS : {{8{v[23]}}, v},
        u_meas_link_if.raw);
    end
    for (int k = 0; k < 4; k++)
    begin
      @(posedge mclk_in);
      br_fault <= (k == 0);
      io_fault <= (k == 1);
      adc_cfg <= (k != 2);
      open_line <= (k == 3);
      repeat (6) @(negedge mclk_in);
      check("invalid flag", (k < 3), {31'h0, u_meas_link_if.status[0]});
      check("open flag", (k == 3), {31'h0, u_meas_link_if.status[1]});
      check("raw fault", (k < 3) ? bridge_pkg::RAW_INVALID : bridge_pkg::RAW_POS_FS,
        u_meas_link_if.raw);
    end
    @(posedge mclk_in) open_line <= 1'b0;
    wr(bridge_pkg::REG_CTRL, 32'h5, 2'b00);
    repeat (4) @(negedge mclk_in);
    check("settling flag", 1, {31'h0, u_meas_link_if.status[2]});
    wr(bridge_pkg::REG_CTRL, 32'h0, 2'b00);
    repeat (4) @(negedge mclk_in);
    check("flags cleared", 0, {29'h0, u_meas_link_if.status[2:0]});
    ms_run(200, 0, 5, 2);
    rd_chk(bridge_pkg::REG_IRQ_ST, 32'hf, 32'hb, 2'b00);
    rd_chk(bridge_pkg::REG_SLOT0, 32'hffff, {16'h0, exp_s0}, 2'b00);
    check("irq masked", 0, {31'h0, irq});
    wr(bridge_pkg::REG_IRQ_MASK, 32'h1, 2'b00);
    check("irq raised", 1, {31'h0, irq});
    wr(bridge_pkg::REG_IRQ_ST, 32'h1, 2'b00);
    check("irq cleared", 0, {31'h0, irq});
    ms_run(300, 1, 3, 0);
    wr(bridge_pkg::REG_SLOT_EN, 32'h9, 2'b00);
    ms_run(550, 0, 3, 0);
    rd_chk(8'h64, 32'hffff, {16'h0, bridge_pkg::SLOT_INVALID}, 2'b00);
    ms_run(275, 0, 3, 0);
    wrap_up();
  end
endmodule : bridge_sensor_result_and_multisample_tb
`default_nettype wire

/* File: hdl/bridge_dev_end.sv */
`default_nettype none
module bridge_dev_end #(
  parameter int SETTLE_CYCLES = bridge_pkg::SETTLE_BUS_CYC
) (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // Link to the controller
  meas_link_if.dev         link,
  // Converter front end, same clock
  input  wire logic [23:0] adc_data_in,
  input  wire logic        adc_valid_in,
  input  wire logic        adc_configured_in,
  // Asynchronous monitor pins
  input  wire logic        open_line_in,
  input  wire logic        bridge_fault_in,
  input  wire logic        io_fault_in,
  // Converter control
  output logic             conv_start_out,
  output logic [2:0]       range_code_out,
  output logic             sync_locked_out
);
  // Settle counter is eight bits wide and must reach its limit
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255)
  begin : g_bad_settle
    $error("SETTLE_CYCLES must be 1..255");
  end

  localparam int N = bridge_pkg::SLOT_COUNT;

  logic [2:0]   pin_s1_r;
  logic [2:0]   pin_s2_r;
  logic         open_s;
  logic         fault;
  logic         sync_active;
  logic [11:0]  period_cyc;
  logic [11:0]  phase_r;
  logic         tick;
  logic [7:0]   settle_r;
  logic [7:0]   period_sel_r;
  logic         locked;
  logic [15:0]  smp;
  bridge_pkg::slot_vec_type sh_r;
  bridge_pkg::slot_vec_type sh_nxt;
  bridge_pkg::slot_vec_type slots_nxt;
  logic [3:0]   cnt_r;
  logic [3:0]   cnt_nxt;
  logic         open_acc_r;
  logic         open_nxt;
  logic [7:0]   status_r;
  logic [31:0]  raw_r;
  bridge_pkg::slot_vec_type slots_r;
  logic         pub_r;
  logic         conv_r;

  // Two-flop synchroniser for the monitor pins
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
    end
    else
    begin
      pin_s1_r <= {io_fault_in, bridge_fault_in, open_line_in};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign open_s = pin_s2_r[0];
  assign fault  = pin_s2_r[1] | pin_s2_r[2] | ~adc_configured_in;
  assign sync_active = link.ms_mode | link.sync_en;

  // Conversion period from the select value; reserved codes run at 50us
  assign period_cyc = (link.period_cfg == bridge_pkg::PERIOD_SEL_B) ?
                      12'(bridge_pkg::PERIOD_B_CYC) :
                      12'(bridge_pkg::PERIOD_A_CYC);
  assign tick = (phase_r >= period_cyc - 12'h001);

  // Conversion phase; a boundary off the tick means the cycle is no
  // multiple of the period, so with sync active the phase restarts from the boundary
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      phase_r <= 12'h000;
    else if (sync_active && link.bus_cycle && !tick)
      phase_r <= 12'h000;
    else if (tick)
      phase_r <= 12'h000;
    else
      phase_r <= phase_r + 12'h001;
  end

  // Settling: count aligned boundaries after enable or period change
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      settle_r     <= 8'h00;
      period_sel_r <= 8'h00;
    end
    else
    begin
      period_sel_r <= link.period_cfg;
      if (!sync_active || period_sel_r != link.period_cfg)
        settle_r <= 8'h00;
      else if (link.bus_cycle && !tick)
        settle_r <= 8'h00;
      else if (link.bus_cycle && settle_r != 8'(SETTLE_CYCLES))
        settle_r <= settle_r + 8'h01;
    end
  end

  assign locked = (settle_r == 8'(SETTLE_CYCLES));

  // One 16-bit sample per tick, coded like the wide value
  always_comb
  begin
    if (fault)
      smp = bridge_pkg::SLOT_INVALID;
    else if (open_s)
      smp = bridge_pkg::SLOT_POS_FS;
    else
      smp = adc_data_in[23:8];
  end

  // Newest sample sits at index 0; older ones fall off the top
  always_comb
  begin
    sh_nxt   = sh_r;
    cnt_nxt  = cnt_r;
    open_nxt = open_acc_r;
    if (tick && link.ms_mode)
    begin
      sh_nxt   = {sh_r[N-2:0], smp};
      open_nxt = open_acc_r | open_s;
      if (cnt_r != 4'(N))
        cnt_nxt = cnt_r + 4'h1;
    end
  end

  // Slot i takes the i-th oldest retained sample
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      if (locked && 4'(i) < cnt_nxt)
        slots_nxt[i] = sh_nxt[4'(cnt_nxt - 4'(i) - 4'h1)];
      else
        slots_nxt[i] = bridge_pkg::SLOT_INVALID;
    end
  end

  // Sample store and per-cycle accumulators
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      sh_r       <= '0;
      cnt_r      <= 4'h0;
      open_acc_r <= 1'b0;
    end
    else if (link.bus_cycle)
    begin
      sh_r       <= sh_nxt;
      cnt_r      <= 4'h0;
      open_acc_r <= 1'b0;
    end
    else
    begin
      sh_r       <= sh_nxt;
      cnt_r      <= cnt_nxt;
      open_acc_r <= open_nxt;
    end
  end

  // Slot bank moves as one at the boundary, so no torn cycle is seen
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      slots_r <= {N{bridge_pkg::SLOT_INVALID}};
    else if (link.ms_mode && link.bus_cycle)
      slots_r <= slots_nxt;
  end

  // Status byte; multisample publishes per cycle, standard live
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      status_r <= 8'h00;
    else if (link.ms_mode)
    begin
      if (link.bus_cycle)
      begin
        status_r <= 8'h00;
        status_r[bridge_pkg::ST_INVALID] <= fault;
        status_r[bridge_pkg::ST_OPEN]    <= open_nxt;
        status_r[bridge_pkg::ST_NOSYNC]  <= ~locked;
      end
    end
    else
    begin
      status_r <= 8'h00;
      status_r[bridge_pkg::ST_INVALID] <= fault;
      status_r[bridge_pkg::ST_OPEN]    <= open_s;
      status_r[bridge_pkg::ST_NOSYNC]  <= link.sync_en & ~locked;
    end
  end

  // Wide raw value; a fault overrides any conversion at once
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      raw_r <= bridge_pkg::RAW_INVALID;
    else if (fault)
      raw_r <= bridge_pkg::RAW_INVALID;
    else if (open_s)
      raw_r <= bridge_pkg::RAW_POS_FS;
    else if (adc_valid_in)
    begin
      if (adc_data_in == bridge_pkg::ADC_MIN)
        raw_r <= bridge_pkg::RAW_NEG_FS;
      else
        raw_r <= {{8{adc_data_in[23]}}, adc_data_in};
    end
  end

  // Publish strobe and converter start
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      pub_r  <= 1'b0;
      conv_r <= 1'b0;
    end
    else
    begin
      pub_r  <= link.bus_cycle;
      conv_r <= tick & sync_active;
    end
  end

  assign link.status     = status_r;
  assign link.raw        = raw_r;
  assign link.slots      = slots_r;
  assign link.pub        = pub_r;
  assign conv_start_out  = conv_r;
  assign range_code_out  = link.range_cfg[2:0];
  assign sync_locked_out = locked;
endmodule : bridge_dev_end
`default_nettype wire

/* File: hdl/bridge_host_end.sv */
`default_nettype none
module bridge_host_end (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // Link to the device
  meas_link_if.host        link,
  // AXI4-Lite write
  input  wire logic [7:0]  axi_awaddr_in,
  input  wire logic        axi_awvalid_in,
  output logic             axi_awready_out,
  input  wire logic [31:0] axi_wdata_in,
  input  wire logic [3:0]  axi_wstrb_in,
  input  wire logic        axi_wvalid_in,
  output logic             axi_wready_out,
  output logic [1:0]       axi_bresp_out,
  output logic             axi_bvalid_out,
  input  wire logic        axi_bready_in,
  // AXI4-Lite read
  input  wire logic [7:0]  axi_araddr_in,
  input  wire logic        axi_arvalid_in,
  output logic             axi_arready_out,
  output logic [31:0]      axi_rdata_out,
  output logic [1:0]       axi_rresp_out,
  output logic             axi_rvalid_out,
  input  wire logic        axi_rready_in,
  // Interrupt
  output logic             irq_out
);
  localparam int N = bridge_pkg::SLOT_COUNT;

  logic        aw_got_r, w_got_r, bvalid_r, rvalid_r, do_wr;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0]  wstrb_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [2:0]  ctrl_r, range_r;
  logic [15:0] cycle_us_r;
  logic [7:0]  period_r;
  logic [3:0]  slot_en_r, irq_st_r, irq_mask_r, irq_set, irq_clr;
  logic [20:0] cyc_len, cyc_cnt_r;
  logic        strobe_r;
  logic [7:0]  stat_r;
  logic [31:0] raw_r;
  bridge_pkg::slot_vec_type slot_r;
  logic [7:0]  ra;

  // Write side: address and data taken in either order
  assign do_wr = aw_got_r & w_got_r & ~bvalid_r;
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      bvalid_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h0;
      wstrb_r  <= 4'h0;
      bresp_r  <= 2'h0;
    end
    else
    begin
      if (axi_awvalid_in && axi_awready_out)
      begin
        aw_got_r <= 1'b1;
        awaddr_r <= axi_awaddr_in;
      end
      if (axi_wvalid_in && axi_wready_out)
      begin
        w_got_r <= 1'b1;
        wdata_r <= axi_wdata_in;
        wstrb_r <= axi_wstrb_in;
      end
      if (do_wr)
      begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= (awaddr_r > bridge_pkg::REG_SLOT_EN) ? 2'h2 : 2'h0;
      end
      else if (axi_bready_in)
        bvalid_r <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      ctrl_r     <= 3'h0;
      cycle_us_r <= bridge_pkg::CYCLE_US_RST;
      range_r    <= 3'h0;
      period_r   <= 8'h00;
      irq_mask_r <= 4'h0;
      slot_en_r  <= bridge_pkg::SLOT_EN_RST;
    end
    else if (do_wr && wstrb_r[0])
    begin
      if (awaddr_r == bridge_pkg::REG_CTRL)
        ctrl_r <= wdata_r[2:0];
      else if (awaddr_r == bridge_pkg::REG_CYCLE && wstrb_r[1])
        cycle_us_r <= wdata_r[15:0];
      else if (awaddr_r == bridge_pkg::REG_RANGE)
        range_r <= wdata_r[2:0];
      else if (awaddr_r == bridge_pkg::REG_PERIOD && wdata_r[7:1] == 7'h00)
        period_r <= wdata_r[7:0];
      else if (awaddr_r == bridge_pkg::REG_IRQ_MASK)
        irq_mask_r <= wdata_r[3:0];
      else if (awaddr_r == bridge_pkg::REG_SLOT_EN && wdata_r[3:0] <= 4'(N))
        slot_en_r <= wdata_r[3:0];
    end
  end

  // Bus cycle timebase; zero length stalls it
  assign cyc_len = 21'(cycle_us_r) * 21'(bridge_pkg::CLK_PER_US);
  always_ff @(posedge mclk_in)
  begin
    if (rst_in || !ctrl_r[0] || cyc_len == 21'h0)
    begin
      cyc_cnt_r <= 21'h0;
      strobe_r  <= 1'b0;
    end
    else if (cyc_cnt_r >= cyc_len - 21'h1)
    begin
      cyc_cnt_r <= 21'h0;
      strobe_r  <= 1'b1;
    end
    else
    begin
      cyc_cnt_r <= cyc_cnt_r + 21'h1;
      strobe_r  <= 1'b0;
    end
  end

  // Snapshot of the cyclic data; disabled slots are not carried
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      stat_r <= 8'h00;
      raw_r  <= bridge_pkg::RAW_INVALID;
      slot_r <= {N{bridge_pkg::SLOT_INVALID}};
    end
    else if (link.pub)
    begin
      stat_r <= link.status;
      raw_r  <= link.raw;
      for (int i = 0; i < N; i++)
        slot_r[i] <= (4'(i) < slot_en_r) ? link.slots[i] :
                     bridge_pkg::SLOT_INVALID;
    end
  end

  // Sticky events; a set in the clearing cycle survives
  assign irq_set = {4{link.pub}} & {link.status[bridge_pkg::ST_NOSYNC],
                   link.status[bridge_pkg::ST_INVALID],
                   link.status[bridge_pkg::ST_OPEN], 1'b1};
  assign irq_clr = (do_wr && wstrb_r[0] && awaddr_r == bridge_pkg::REG_IRQ_ST) ?
                   wdata_r[3:0] : 4'h0;
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      irq_st_r <= 4'h0;
    else
      irq_st_r <= (irq_st_r & ~irq_clr) | irq_set;
  end

  // Read side, one word per request
  assign ra = axi_araddr_in - bridge_pkg::REG_SLOT0;
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= 2'h0;
    end
    else if (axi_arvalid_in && axi_arready_out)
    begin
      rvalid_r <= 1'b1;
      rresp_r  <= 2'h0;
      rdata_r  <= 32'h0;
      if (axi_araddr_in == bridge_pkg::REG_CTRL)
        rdata_r <= {29'h0, ctrl_r};
      else if (axi_araddr_in == bridge_pkg::REG_CYCLE)
        rdata_r <= {16'h0, cycle_us_r};
      else if (axi_araddr_in == bridge_pkg::REG_RANGE)
        rdata_r <= {29'h0, range_r};
      else if (axi_araddr_in == bridge_pkg::REG_PERIOD)
        rdata_r <= {24'h0, period_r};
      else if (axi_araddr_in == bridge_pkg::REG_STATUS)
        rdata_r <= {24'h0, stat_r};
      else if (axi_araddr_in == bridge_pkg::REG_RAW)
        rdata_r <= raw_r;
      else if (axi_araddr_in == bridge_pkg::REG_IRQ_ST)
        rdata_r <= {28'h0, irq_st_r};
      else if (axi_araddr_in == bridge_pkg::REG_IRQ_MASK)
        rdata_r <= {28'h0, irq_mask_r};
      else if (axi_araddr_in == bridge_pkg::REG_SLOT_EN)
        rdata_r <= {28'h0, slot_en_r};
      else if (axi_araddr_in >= bridge_pkg::REG_SLOT0 && ra[1:0] == 2'h0 &&
               ra[7:2] < 6'(N))
        rdata_r <= {16'h0, slot_r[ra[5:2]]};
      else
        rresp_r <= 2'h2;
    end
    else if (axi_rready_in)
      rvalid_r <= 1'b0;
  end

  assign axi_awready_out = ~aw_got_r & ~bvalid_r;
  assign axi_wready_out  = ~w_got_r & ~bvalid_r;
  assign axi_bvalid_out  = bvalid_r;
  assign axi_bresp_out   = bresp_r;
  assign axi_arready_out = ~rvalid_r;
  assign axi_rvalid_out  = rvalid_r;
  assign axi_rdata_out   = rdata_r;
  assign axi_rresp_out   = rresp_r;
  assign irq_out         = |(irq_st_r & irq_mask_r);

  // One channel only; multisample is tied to it
  assign link.bus_cycle  = strobe_r;
  assign link.ms_mode    = ctrl_r[1];
  assign link.sync_en    = ctrl_r[2];
  assign link.range_cfg  = {5'h00, range_r};
  assign link.period_cfg = period_r;
endmodule : bridge_host_end
`default_nettype wire

/* File: hdl/bridge_pkg.sv */
`default_nettype none
package bridge_pkg;
  // Clock and conversion timing
  localparam int CLK_HZ         = 20_000_000;
  localparam int CLK_PER_US     = CLK_HZ / 1_000_000;
  localparam int PERIOD_A_US    = 50;
  localparam int PERIOD_B_US    = 100;
  localparam int PERIOD_A_CYC   = PERIOD_A_US * CLK_PER_US;
  localparam int PERIOD_B_CYC   = PERIOD_B_US * CLK_PER_US;
  localparam int SETTLE_BUS_CYC = 150;
  localparam int SLOT_COUNT     = 10;

  // Codes on the link
  localparam logic [7:0]  PERIOD_SEL_B = 8'h01;
  localparam logic [31:0] RAW_INVALID  = 32'hff800000;
  localparam logic [31:0] RAW_NEG_FS   = 32'hff800001;
  localparam logic [31:0] RAW_POS_FS   = 32'h007fffff;
  localparam logic [23:0] ADC_MIN      = 24'h800000;
  localparam logic [15:0] SLOT_INVALID = 16'h8000;
  localparam logic [15:0] SLOT_POS_FS  = 16'h7fff;
  localparam int ST_INVALID = 0;
  localparam int ST_OPEN    = 1;
  localparam int ST_NOSYNC  = 2;

  // Controller register map, byte addresses
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_CYCLE    = 8'h04;
  localparam logic [7:0] REG_RANGE    = 8'h08;
  localparam logic [7:0] REG_PERIOD   = 8'h0c;
  localparam logic [7:0] REG_STATUS   = 8'h10;
  localparam logic [7:0] REG_RAW      = 8'h14;
  localparam logic [7:0] REG_IRQ_ST   = 8'h18;
  localparam logic [7:0] REG_IRQ_MASK = 8'h1c;
  localparam logic [7:0] REG_SLOT_EN  = 8'h20;
  localparam logic [7:0] REG_SLOT0    = 8'h40;
  localparam logic [15:0] CYCLE_US_RST = 16'h0190;
  localparam logic [3:0]  SLOT_EN_RST  = 4'ha;

  // Interrupt bits
  localparam int IRQ_NEW    = 0;
  localparam int IRQ_OPEN   = 1;
  localparam int IRQ_INVAL  = 2;
  localparam int IRQ_NOSYNC = 3;

  typedef logic [SLOT_COUNT-1:0][15:0] slot_vec_type;
endpackage : bridge_pkg
`default_nettype wire

/* File: hdl/meas_link_if.sv */
`default_nettype none
interface meas_link_if;
  logic                        bus_cycle;
  logic                        ms_mode;
  logic                        sync_en;
  logic [7:0]                  range_cfg;
  logic [7:0]                  period_cfg;
  logic [7:0]                  status;
  logic [31:0]                 raw;
  bridge_pkg::slot_vec_type    slots;
  logic                        pub;

  modport dev (
    input  bus_cycle, ms_mode, sync_en, range_cfg, period_cfg,
    output status, raw, slots, pub
  );
  modport host (
    output bus_cycle, ms_mode, sync_en, range_cfg, period_cfg,
    input  status, raw, slots, pub
  );
endinterface : meas_link_if
`default_nettype wire
